// *** rtl/lo_offset_if_config.sv ***
// lo path, offset divider and if configuration registers behind a 3-wire spi
`timescale 1ns/1ps
module lo_offset_if_config (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       csb_n,
  input  wire logic       sdio_in,
  input  wire logic       lo_in,
  input  wire logic       of_in,
  input  wire logic       align_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  output logic            lo_direct_en,
  output logic            lo_mult_en,
  output logic [1:0]      lo_factor_sel,
  output logic            offset_mix_en,
  output logic [1:0]      offset_factor_sel,
  output logic [7:0]      filter_tune_a,
  output logic [7:0]      filter_tune_b,
  output logic [7:0]      if_bandwidth,
  output logic [7:0]      if_gain_fwd,
  output logic [7:0]      if_gain_rev,
  output logic            lo_div_out,
  output logic            offset_div_out
);
  // pin order inside the synchroniser vectors
  localparam int P_SCLK = 0;
  localparam int P_CSB  = 1;
  localparam int P_SDIO = 2;
  localparam int P_LO   = 3;
  localparam int P_OF   = 4;
  localparam int P_ALN  = 5;

  typedef struct packed {
    logic [lo_cfg_pkg::SYNC_PINS-1:0] sync1;
    logic [lo_cfg_pkg::SYNC_PINS-1:0] sync2;
    logic [lo_cfg_pkg::SYNC_PINS-1:0] sync3;
    logic [lo_cfg_pkg::SYNC_PINS-1:0] filt;
    lo_cfg_pkg::spi_phase_t           phase;
    logic [4:0]                       bit_cnt;
    logic [7:0]                       shift;
    logic                             rd_mode;
    logic [6:0]                       addr;
    logic [7:0]                       rd_data;
    logic                             sdio_out;
    logic                             sdio_oe;
    logic [7:0]                       lo_path;
    logic [7:0]                       tune_a;
    logic [7:0]                       tune_b;
    logic [7:0]                       bw;
    logic [7:0]                       gain_f;
    logic [7:0]                       gain_r;
    logic                             aligned;
    logic                             lo_direct;
    logic                             lo_mult;
    logic [1:0]                       lo_sel;
    logic                             of_mix;
    logic [1:0]                       of_sel;
  } cfg_state_t;

  cfg_state_t                       s_reg;
  cfg_state_t                       s_next;
  logic [lo_cfg_pkg::SYNC_PINS-1:0] agree;
  logic [lo_cfg_pkg::SYNC_PINS-1:0] rise;
  logic [lo_cfg_pkg::SYNC_PINS-1:0] fall;
  logic [7:0]                       wr_data;
  div_if                            dv ();

  // ****************************************
  // register read decode
  // ****************************************
  function automatic logic [7:0] reg_read(input cfg_state_t st, input logic [6:0] a);
    unique case (a)
      lo_cfg_pkg::ADDR_LO_PATH_CONFIG:      reg_read = st.lo_path;
      lo_cfg_pkg::ADDR_LO_FILTER_TUNE_A:    reg_read = st.tune_a;
      lo_cfg_pkg::ADDR_LO_FILTER_TUNE_B:    reg_read = st.tune_b;
      lo_cfg_pkg::ADDR_IF_BANDWIDTH_SELECT: reg_read = st.bw;
      lo_cfg_pkg::ADDR_IF_GAIN_FWD:         reg_read = st.gain_f;
      lo_cfg_pkg::ADDR_IF_GAIN_REV:         reg_read = st.gain_r;
      lo_cfg_pkg::ADDR_ALIGN_STATUS:        reg_read = {5'h00, offset_div_out, lo_div_out,
                                                        st.aligned};
      default:                              reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    // a pin change counts once the second and third stages agree
    agree   = ~(s_reg.sync2 ^ s_reg.sync3);
    rise    = agree & s_reg.sync3 & ~s_reg.filt;
    fall    = agree & ~s_reg.sync3 & s_reg.filt;
    wr_data = {s_reg.shift[6:0], s_reg.sync3[P_SDIO]};
    s_next.sync1 = {align_in, of_in, lo_in, sdio_in, csb_n, sclk};
    s_next.sync2 = s_reg.sync1;
    s_next.sync3 = s_reg.sync2;
    s_next.filt  = (agree & s_reg.sync3) | (~agree & s_reg.filt);

    if (s_reg.filt[P_CSB]) begin
      // deselect aborts any partial frame; a write only lands on its last bit
      s_next.phase   = lo_cfg_pkg::SPI_CMD;
      s_next.bit_cnt = 5'h00;
      s_next.sdio_oe = 1'b0;
    end else begin
      if (rise[P_SCLK] && s_reg.phase != lo_cfg_pkg::SPI_DONE) begin
        s_next.shift   = wr_data;
        s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
        if (s_reg.bit_cnt == lo_cfg_pkg::SPI_LAST_ADDR_BIT) begin
          s_next.rd_mode = s_reg.shift[6];
          s_next.addr    = wr_data[6:0];
          s_next.rd_data = reg_read(s_reg, wr_data[6:0]);
          s_next.phase   = lo_cfg_pkg::SPI_DATA;
        end
        if (s_reg.bit_cnt == lo_cfg_pkg::SPI_LAST_DATA_BIT) begin
          s_next.phase = lo_cfg_pkg::SPI_DONE;
          if (!s_reg.rd_mode) begin
            unique case (s_reg.addr)
              lo_cfg_pkg::ADDR_LO_FILTER_TUNE_A:    s_next.tune_a = wr_data;
              lo_cfg_pkg::ADDR_LO_FILTER_TUNE_B:    s_next.tune_b = wr_data;
              lo_cfg_pkg::ADDR_LO_PATH_CONFIG:      s_next.lo_path = wr_data;
              lo_cfg_pkg::ADDR_IF_BANDWIDTH_SELECT: s_next.bw = wr_data;
              lo_cfg_pkg::ADDR_IF_GAIN_FWD:         s_next.gain_f = wr_data;
              lo_cfg_pkg::ADDR_IF_GAIN_REV:         s_next.gain_r = wr_data;
              default:                              s_next.addr = s_reg.addr;
            endcase
          end
        end
      end
      if (fall[P_SCLK] && s_reg.rd_mode && s_reg.phase == lo_cfg_pkg::SPI_DATA) begin
        s_next.sdio_oe  = 1'b1;
        s_next.sdio_out = s_reg.rd_data[7];
        s_next.rd_data  = {s_reg.rd_data[6:0], 1'b0};
      end
    end

    // one align edge is enough; the flag stays set
    if (rise[P_ALN]) begin
      s_next.aligned = 1'b1;
    end

    s_next.lo_direct = s_next.lo_path[lo_cfg_pkg::BYPASS_BIT];
    s_next.lo_sel = s_next.lo_direct ? 2'h1 : s_next.lo_path[lo_cfg_pkg::LO_MUL_SEL_LSB +: 2];
    s_next.lo_mult = !s_next.lo_direct && s_next.lo_sel[1];
    s_next.of_sel = s_next.lo_direct ? lo_cfg_pkg::OF_SEL_OFF
                                     : s_next.lo_path[lo_cfg_pkg::OF_DIV_SEL_LSB +: 2];
    s_next.of_mix = s_next.of_sel != lo_cfg_pkg::OF_SEL_OFF;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg         <= '0;
      s_reg.filt    <= {lo_cfg_pkg::SYNC_PINS{1'b0}} | 6'h02;
      s_reg.sync1   <= 6'h02;
      s_reg.sync2   <= 6'h02;
      s_reg.sync3   <= 6'h02;
      s_reg.lo_path <= lo_cfg_pkg::LO_PATH_CONFIG_RST;
      s_reg.tune_a  <= lo_cfg_pkg::REG_RST;
      s_reg.of_sel  <= lo_cfg_pkg::OF_SEL_DIV4;
      s_reg.of_mix  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // dividers
  // ****************************************
  // divider edges and align come from the filtered pins
  assign dv.lo_edge    = rise[P_LO] | fall[P_LO];
  assign dv.of_edge    = rise[P_OF] | fall[P_OF];
  assign dv.align      = rise[P_ALN];
  assign dv.lo_half_en = !s_reg.lo_direct && s_reg.lo_sel == lo_cfg_pkg::LO_SEL_DIV2;
  assign dv.of_sel     = s_reg.of_sel;

  lo_of_divider u_div (
    .clock (clock),
    .rst   (rst),
    .dv    (dv.div)
  );

  assign sdio_out          = s_reg.sdio_out;
  assign sdio_oe           = s_reg.sdio_oe;
  assign lo_direct_en      = s_reg.lo_direct;
  assign lo_mult_en        = s_reg.lo_mult;
  assign lo_factor_sel     = s_reg.lo_sel;
  assign offset_mix_en     = s_reg.of_mix;
  assign offset_factor_sel = s_reg.of_sel;
  assign filter_tune_a     = s_reg.tune_a;
  assign filter_tune_b     = s_reg.tune_b;
  assign if_bandwidth      = s_reg.bw;
  assign if_gain_fwd       = s_reg.gain_f;
  assign if_gain_rev       = s_reg.gain_r;
  assign lo_div_out        = dv.lo_out;
  assign offset_div_out    = dv.of_out;

  // ****************************************
  // checks
  // ****************************************
  a_bypass_direct: assert property (@(posedge clock) disable iff (rst)
    s_reg.lo_path[lo_cfg_pkg::BYPASS_BIT] == lo_direct_en)
    else $error("bypass output does not follow bit 4");
  a_bypass_path_idle: assert property (@(posedge clock) disable iff (rst)
    lo_direct_en |-> (!lo_mult_en && !offset_mix_en && !dv.lo_half_en))
    else $error("multiplier or offset path active in bypass");
  // bypass must already stand: the write that enters bypass moves the select on purpose
  a_bypass_fields_masked: assert property (@(posedge clock) disable iff (rst)
    (lo_direct_en && $past(lo_direct_en) && $changed(s_reg.lo_path[3:0]))
    |-> ($stable(lo_factor_sel) && offset_factor_sel == lo_cfg_pkg::OF_SEL_OFF))
    else $error("select fields leak through bypass");
  a_lo_factor_sel: assert property (@(posedge clock) disable iff (rst)
    !lo_direct_en |-> (lo_factor_sel == s_reg.lo_path[1:0] && lo_mult_en == lo_factor_sel[1]))
    else $error("lo factor select wrong");
  a_of_sel_decode: assert property (@(posedge clock) disable iff (rst)
    !lo_direct_en |-> (offset_factor_sel == s_reg.lo_path[3:2]
    && offset_mix_en == (s_reg.lo_path[3:2] != lo_cfg_pkg::OF_SEL_OFF)))
    else $error("offset select decode wrong");
  a_tune_write: assert property (@(posedge clock) disable iff (rst)
    (rise[P_SCLK] && !s_reg.filt[P_CSB] && !s_reg.rd_mode && s_reg.bit_cnt == 5'h0F
    && s_reg.addr == lo_cfg_pkg::ADDR_LO_FILTER_TUNE_A) |=> filter_tune_a == $past(wr_data))
    else $error("tune register write lost");
  a_gain_separate: assert property (@(posedge clock) disable iff (rst)
    $changed(if_gain_fwd) |-> $stable(if_gain_rev))
    else $error("gain channels not independent");
  a_align_single: assert property (@(posedge clock) disable iff (rst)
    rise[P_ALN] |=> s_reg.aligned ##1 s_reg.aligned)
    else $error("single align pulse not enough");
  a_sdio_release: assert property (@(posedge clock) disable iff (rst)
    s_reg.filt[P_CSB] |=> !sdio_oe)
    else $error("sdio driven while deselected");
endmodule : lo_offset_if_config

// *** rtl/lo_cfg_pkg.sv ***
// constants for the lo / offset / if configuration block
package lo_cfg_pkg;
  // ****************************************
  // register addresses (7-bit spi address)
  // ****************************************
  localparam logic [6:0] ADDR_LO_PATH_CONFIG     = 7'h20;
  localparam logic [6:0] ADDR_LO_FILTER_TUNE_A   = 7'h21;
  localparam logic [6:0] ADDR_LO_FILTER_TUNE_B   = 7'h22;
  localparam logic [6:0] ADDR_IF_BANDWIDTH_SELECT = 7'h25;
  localparam logic [6:0] ADDR_IF_GAIN_FWD        = 7'h26;
  localparam logic [6:0] ADDR_IF_GAIN_REV        = 7'h27;
  localparam logic [6:0] ADDR_ALIGN_STATUS       = 7'h28;

  // ****************************************
  // lo_path_config fields
  // ****************************************
  localparam int BYPASS_BIT     = 4;
  localparam int LO_MUL_SEL_LSB = 0;
  localparam int OF_DIV_SEL_LSB = 2;

  // ****************************************
  // reset values and encodings
  // ****************************************
  localparam logic [7:0] LO_PATH_CONFIG_RST = 8'h08;
  localparam logic [7:0] REG_RST            = 8'h00;
  localparam logic [1:0] LO_SEL_DIV2        = 2'h0;
  localparam logic [1:0] OF_SEL_DIV1        = 2'h0;
  localparam logic [1:0] OF_SEL_DIV2        = 2'h1;
  localparam logic [1:0] OF_SEL_DIV4        = 2'h2;
  localparam logic [1:0] OF_SEL_OFF         = 2'h3;

  // ****************************************
  // spi framing and pin synchroniser
  // ****************************************
  localparam logic [4:0] SPI_LAST_ADDR_BIT = 5'h07;
  localparam logic [4:0] SPI_LAST_DATA_BIT = 5'h0F;
  localparam int         SYNC_PINS         = 6;

  typedef enum logic [1:0] {
    SPI_CMD  = 2'b00,
    SPI_DATA = 2'b01,
    SPI_DONE = 2'b11
  } spi_phase_t;
endpackage : lo_cfg_pkg

// *** rtl/div_if.sv ***
// carrier between configuration logic and the lo / offset dividers
`timescale 1ns/1ps
interface div_if;
  logic       lo_edge;
  logic       of_edge;
  logic       align;
  logic       lo_half_en;
  logic [1:0] of_sel;
  logic       lo_out;
  logic       of_out;
  modport ctrl (output lo_edge, of_edge, align, lo_half_en, of_sel, input lo_out, of_out);
  modport div  (input lo_edge, of_edge, align, lo_half_en, of_sel, output lo_out, of_out);
endinterface : div_if

// *** rtl/lo_of_divider.sv ***
// digital lo divide-by-2 and offset divide-by-1/2/4 with alignment
`timescale 1ns/1ps
module lo_of_divider (
  input  wire logic clock,
  input  wire logic rst,
  div_if.div        dv
);
  typedef struct packed {
    logic [1:0] lo_cnt;
    logic [2:0] of_cnt;
    logic       lo_out;
    logic       of_out;
  } div_state_t;

  div_state_t s_reg;
  div_state_t s_next;

  // edges count both transitions of the input, so bit k toggles every 2^k edges
  always_comb begin
    s_next = s_reg;
    if (dv.align) begin
      s_next.lo_cnt = 2'h0;
      s_next.of_cnt = 3'h0;
    end else begin
      if (dv.lo_edge && dv.lo_half_en) begin
        s_next.lo_cnt = s_reg.lo_cnt + 2'h1;
      end
      if (dv.of_edge && dv.of_sel != lo_cfg_pkg::OF_SEL_OFF) begin
        s_next.of_cnt = s_reg.of_cnt + 3'h1;
      end
    end
    s_next.lo_out = dv.lo_half_en ? s_next.lo_cnt[1] : 1'b0;
    unique case (dv.of_sel)
      lo_cfg_pkg::OF_SEL_DIV1: s_next.of_out = s_next.of_cnt[0];
      lo_cfg_pkg::OF_SEL_DIV2: s_next.of_out = s_next.of_cnt[1];
      lo_cfg_pkg::OF_SEL_DIV4: s_next.of_out = s_next.of_cnt[2];
      lo_cfg_pkg::OF_SEL_OFF:  s_next.of_out = 1'b0;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dv.lo_out = s_reg.lo_out;
  assign dv.of_out = s_reg.of_out;

  a_div_align_zero: assert property (@(posedge clock) disable iff (rst)
    dv.align |=> (s_reg.lo_cnt == 2'h0 && s_reg.of_cnt == 3'h0 && !dv.lo_out))
    else $error("dividers not cleared by align");
  // an align while off may still clear the counter, so it is left out here
  a_of_off_quiet: assert property (@(posedge clock) disable iff (rst)
    (dv.of_sel == lo_cfg_pkg::OF_SEL_OFF && !dv.align)
    |=> (!dv.of_out && $stable(s_reg.of_cnt)))
    else $error("offset divider runs while off");
  a_of_div4_rate: assert property (@(posedge clock) disable iff (rst)
    (dv.of_sel == lo_cfg_pkg::OF_SEL_DIV4 && !dv.align && dv.of_edge && s_reg.of_cnt == 3'h3)
    |=> (dv.of_out && s_reg.of_cnt == 3'h4))
    else $error("divide by 4 output wrong");
endmodule : lo_of_divider

// *** testbench/spi_host_model.sv ***
// spi host model that frames register accesses on the 3-wire port
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clock,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  output logic      sclk,
  output logic      csb_n,
  output logic      sdio_in
);
  int   half_clks = 6;
  logic host_bit  = 1'b0;
  logic host_oe   = 1'b0;

  // a released line shows the inverse of its last value, never a stale copy
  assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_bit : ~host_bit);

  initial begin
    sclk  = 1'b0;
    csb_n = 1'b1;
  end

  task automatic wait_clks(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : wait_clks

  // ****************************************
  // one frame: rw, 7-bit address, 8 data bits, msb first
  // ****************************************
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {rd, addr, wdata};
    rdata = 8'h00;
    csb_n = 1'b0;
    wait_clks(half_clks);
    for (int i = 15; i >= 0; i--) begin
      host_oe = !(rd && i < 8);
      if (host_oe) host_bit = frame[i];
      wait_clks(half_clks);
      if (!host_oe) rdata[i] = sdio_in;
      sclk = 1'b1;
      wait_clks(half_clks);
      sclk = 1'b0;
    end
    wait_clks(half_clks);
    csb_n   = 1'b1;
    host_oe = 1'b0;
    // frames stay apart by well over the minimum gap
    wait_clks(2 * half_clks);
  endtask : xfer
endmodule : spi_host_model

// *** testbench/lo_offset_if_config_test.sv ***
// self-checking bench for the lo / offset / if configuration block
`timescale 1ns/1ps
module lo_offset_if_config_test;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       lo_in = 1'b0;
  logic       of_in = 1'b0;
  logic       align_in = 1'b0;
  logic       sclk, csb_n, sdio_in, sdio_out, sdio_oe;
  logic       lo_direct_en, lo_mult_en, offset_mix_en, lo_div_out, offset_div_out;
  logic [1:0] lo_factor_sel, offset_factor_sel;
  logic [7:0] filter_tune_a, filter_tune_b, if_bandwidth, if_gain_fwd, if_gain_rev;
  int         failures = 0;
  int         checks_done = 0;

  always #12.5 clock = ~clock;

  lo_offset_if_config u_dut (.clock, .rst, .sclk, .csb_n, .sdio_in, .lo_in, .of_in,
    .align_in, .sdio_out, .sdio_oe, .lo_direct_en, .lo_mult_en, .lo_factor_sel,
    .offset_mix_en, .offset_factor_sel, .filter_tune_a, .filter_tune_b, .if_bandwidth,
    .if_gain_fwd, .if_gain_rev, .lo_div_out, .offset_div_out);

  spi_host_model u_host (.clock, .sdio_out, .sdio_oe, .sclk, .csb_n, .sdio_in);

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_host.xfer(1'b0, a, d, unused);
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    u_host.xfer(1'b1, a, 8'h00, d);
  endtask : rd

  task automatic align_pulse;
    @(posedge clock); #2 align_in = 1'b1;
    repeat (4) @(posedge clock);
    #2 align_in = 1'b0;
    repeat (8) @(posedge clock);
    #2;
  endtask : align_pulse

  // toggles the chosen input edge by edge and counts output changes
  task automatic count_toggles(input logic use_lo, input int edges, output int n);
    logic prev;
    n    = 0;
    prev = use_lo ? lo_div_out : offset_div_out;
    for (int e = 0; e < edges + 3; e++) begin
      @(posedge clock); #2;
      if (e < edges) begin
        if (use_lo) lo_in = ~lo_in;
        else of_in = ~of_in;
      end
      repeat (3) @(posedge clock);
      #2;
      if ((use_lo ? lo_div_out : offset_div_out) !== prev) begin
        n++;
        prev = ~prev;
      end
    end
  endtask : count_toggles

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset;
    logic [7:0] d;
    check("offset_mix_en", offset_mix_en, 8'h01);
    check("offset_factor_sel", offset_factor_sel, 8'h02);
    check("lo_direct_en", lo_direct_en, 8'h00);
    rd(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, d);
    check("lo_path_config", d, 8'h08);
    check("sdio_oe", sdio_oe, 8'h00);
    $display("test reset done");
  endtask : test_reset

  task automatic test_align;
    logic [7:0] d;
    // one pulse before any lo activity
    align_pulse();
    check("lo_div_out", lo_div_out, 8'h00);
    check("offset_div_out", offset_div_out, 8'h00);
    rd(lo_cfg_pkg::ADDR_ALIGN_STATUS, d);
    check("align_status", d, 8'h01);
    $display("test align done");
  endtask : test_align

  task automatic test_lo_select;
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, {6'h02, s[1:0]});
      check("lo_factor_sel", lo_factor_sel, s[7:0]);
      check("lo_mult_en", lo_mult_en, {7'h00, s[1]});
      check("lo_direct_en", lo_direct_en, 8'h00);
      align_pulse();
      count_toggles(1'b1, 16, n);
      check("lo_div toggles", n[7:0], (s == 0) ? 8'h08 : 8'h00);
    end
    $display("test lo select done");
  endtask : test_lo_select

  task automatic test_offset;
    int n;
    for (int s = 0; s < 4; s++) begin
      // bypass clear and offset field programmed
      wr(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, {4'h0, s[1:0], 2'h1});
      check("offset_factor_sel", offset_factor_sel, s[7:0]);
      check("offset_mix_en", offset_mix_en, {7'h00, s != 3});
      align_pulse();
      count_toggles(1'b0, 16, n);
      check("offset toggles", n[7:0], (s == 3) ? 8'h00 : 8'h10 >> s);
    end
    // leave the preferred divide by four in place
    wr(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, 8'h08);
    $display("test offset done");
  endtask : test_offset

  task automatic test_bypass;
    logic [7:0] d;
    int         n;
    wr(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, 8'h14);
    check("lo_direct_en", lo_direct_en, 8'h01);
    check("lo_factor_sel", lo_factor_sel, 8'h01);
    check("offset_factor_sel", offset_factor_sel, 8'h03);
    check("offset_mix_en", offset_mix_en, 8'h00);
    check("lo_mult_en", lo_mult_en, 8'h00);
    count_toggles(1'b1, 8, n);
    check("lo_div toggles", n[7:0], 8'h00);
    count_toggles(1'b0, 8, n);
    check("offset toggles", n[7:0], 8'h00);
    // slow host: each sclk level held three times longer
    u_host.half_clks = 18;
    rd(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, d);
    u_host.half_clks = 6;
    check("lo_path_config", d, 8'h14);
    // fields rewritten while bypass stands must not reach the mixer path
    wr(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, 8'h1B);
    check("lo_factor_sel", lo_factor_sel, 8'h01);
    check("offset_factor_sel", offset_factor_sel, 8'h03);
    check("lo_mult_en", lo_mult_en, 8'h00);
    check("offset_mix_en", offset_mix_en, 8'h00);
    wr(lo_cfg_pkg::ADDR_LO_PATH_CONFIG, 8'h08);
    check("lo_direct_en", lo_direct_en, 8'h00);
    $display("test bypass done");
  endtask : test_bypass

  task automatic test_regs;
    logic [6:0] addr [5] = '{7'h21, 7'h22, 7'h25, 7'h26, 7'h27};
    logic [7:0] val  [5] = '{8'hA5, 8'h5A, 8'hC3, 8'h3C, 8'h81};
    logic [7:0] d;
    foreach (addr[i]) wr(addr[i], val[i]);
    wr(7'h30, 8'hFF);
    check("filter_tune_a", filter_tune_a, 8'hA5);
    check("filter_tune_b", filter_tune_b, 8'h5A);
    check("if_bandwidth", if_bandwidth, 8'hC3);
    check("if_gain_fwd", if_gain_fwd, 8'h3C);
    check("if_gain_rev", if_gain_rev, 8'h81);
    foreach (addr[i]) begin
      rd(addr[i], d);
      check("readback", d, val[i]);
    end
    rd(7'h30, d);
    check("unmapped read", d, 8'h00);
    $display("test regs done");
  endtask : test_regs

  initial begin
    repeat (16) @(posedge clock);
    #2 rst = 1'b0;
    repeat (2) @(posedge clock);
    #2;
    test_reset();
    test_align();
    test_lo_select();
    test_offset();
    test_bypass();
    test_regs();
    final_report();
  end

  // hang guard: a run this long counts as a mismatch
  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    final_report();
  end
endmodule : lo_offset_if_config_test
